// ==== adchp_pkg.sv ====
// Package for the converter host data port: constants and carrier types
package adchp_pkg;
	localparam int ADCHP_CHANNELS = 8;
	localparam int ADCHP_RES_BITS = 18;
	localparam int ADCHP_CH_BITS = 3;
	localparam int ADCHP_CLK_MHZ = 10;
	// Reset pulse lengths in ns; at least as long as the full figure gives a full reset
	localparam int ADCHP_PARTIAL_RESET_NS = 50;
	localparam int ADCHP_FULL_RESET_NS = 3000;
	localparam int ADCHP_PARTIAL_CYC = (ADCHP_PARTIAL_RESET_NS * ADCHP_CLK_MHZ + 999) / 1000;
	localparam int ADCHP_FULL_CYC = (ADCHP_FULL_RESET_NS * ADCHP_CLK_MHZ + 999) / 1000;
	// Conversion time per channel in ns
	localparam int ADCHP_CONV_NS = 500;
	localparam int ADCHP_CONV_CYC = (ADCHP_CONV_NS * ADCHP_CLK_MHZ + 999) / 1000;
	localparam int ADCHP_FIFO_DEPTH = 16;
	// Result layout on the parallel pins
	localparam int ADCHP_TOP_BIT = 16;
	localparam int ADCHP_LSB = 0;
	localparam int ADCHP_LOW_FIRST = 2;
	localparam int ADCHP_LOW_LAST = 4;
	localparam int ADCHP_SER_FIRST = 5;
	localparam int ADCHP_SER_LAST = 10;
	localparam int ADCHP_PINS = 17;
	localparam logic [17:0] ADCHP_SEED = 18'h2A5C3;
	typedef struct packed {
		logic [ADCHP_CH_BITS-1:0] channel;
		logic [ADCHP_RES_BITS-1:0] value;
	} adchp_word_type;
	typedef struct packed {
		logic [ADCHP_PINS-1:0] out;
		logic [ADCHP_PINS-1:0] oe_n;
	} adchp_pins_type;
	typedef enum logic [1:0] {ADCHP_RST_NONE, ADCHP_RST_PARTIAL, ADCHP_RST_FULL} adchp_rst_type;
endpackage : adchp_pkg

// ==== adchp_fifo.sv ====
// Result FIFO between conversion and host link
`timescale 1ns/1ps
module adchp_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = (AW+1)'(cnt_reg + push - pop);
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end
	assign in_ready = cnt_reg != (AW+1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = mem_reg[rd_reg];
endmodule : adchp_fifo

// ==== adchp_port.sv ====
// Converter host data port: conversion sequencing, reset decode, parallel and serial readback
// Notes on behaviour
// - Reset pin is active high and the device is in reset while it is high.
// - Pulse length alone chooses between partial and full reset.
// - The read strobe pin is the parallel read strobe or the serial clock by interface.
// - Low chip select gates every result read on both interfaces.
// - Busy rises within three clocks of the rising edge of the conversion start strobe.
// - Busy stays high until all channels are converted.
// - The first channel flag is high while channel one is read back.
// - Parallel data pins are three-state, driven only for reads.
// - Bits 16 to 0 go out on the first read pulse and zeros below the top pin on the second.
// - In serial mode pins of bits 5 to 10 are serial lines E, F, G, H, A, B.
// - In serial mode pins of bits 2 to 4 carry nothing.
// - Interface select low picks parallel, high picks serial.
// - A rising conversion start while no conversion runs samples all eight channels at once.
// - The top pin carries bit 16 first and bit 0 on the second pulse.
`timescale 1ns/1ps
module adchp_port
	import adchp_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic link_clock,
	input wire logic conversion_start_strobe,
	input wire logic interface_select,
	input wire logic chip_select_n,
	input wire logic [ADCHP_CHANNELS*ADCHP_RES_BITS-1:0] analog_codes,
	input wire logic [ADCHP_PINS-1:0] data_in,
	output logic [ADCHP_PINS-1:0] data_out,
	output logic [ADCHP_PINS-1:0] data_oe_n,
	output logic busy,
	output logic first_channel_flag,
	output logic [1:0] reset_kind,
	output logic [ADCHP_PINS-1:0] host_bus_capture
);
	// The read strobe / serial clock pin is the link clock port
	// Input synchronisers on the core clock
	logic [1:0] cv_sync_reg, cv_sync_next;
	logic cv_prev_reg, cv_prev_next;
	logic rst_prev_reg, rst_prev_next;
	logic [11:0] rst_cnt_reg, rst_cnt_next;
	adchp_rst_type rst_kind_reg, rst_kind_next;
	logic [ADCHP_CHANNELS*ADCHP_RES_BITS-1:0] samp_reg, samp_next;
	logic [ADCHP_CH_BITS-1:0] ch_reg, ch_next;
	logic [7:0] cyc_reg, cyc_next;
	logic busy_reg, busy_next;
	logic conv_reg, conv_next;
	adchp_word_type push_word;
	logic push_valid, push_ready;
	adchp_word_type pop_word;
	logic pop_valid, pop_ready;
	logic cv_rise;
	function automatic logic [ADCHP_RES_BITS-1:0] pick(
		input logic [ADCHP_CHANNELS*ADCHP_RES_BITS-1:0] v, input logic [ADCHP_CH_BITS-1:0] c);
		pick = v[c*ADCHP_RES_BITS +: ADCHP_RES_BITS];
	endfunction : pick
	always_comb begin
		cv_sync_next = {cv_sync_reg[0], conversion_start_strobe};
		cv_prev_next = cv_sync_reg[1];
		cv_rise = cv_sync_reg[1] && !cv_prev_reg;
		rst_prev_next = reset;
		// Measure reset pulse; kind decided on release
		rst_cnt_next = 12'h001;
		if (reset && rst_prev_reg) begin
			rst_cnt_next = (rst_cnt_reg == 12'hFFF) ? rst_cnt_reg : 12'(rst_cnt_reg + 1'b1);
		end
		rst_kind_next = rst_kind_reg;
		if (rst_prev_reg && !reset) begin
			rst_kind_next = (rst_cnt_reg >= 12'(ADCHP_FULL_CYC)) ? ADCHP_RST_FULL :
				(rst_cnt_reg >= 12'(ADCHP_PARTIAL_CYC)) ? ADCHP_RST_PARTIAL : ADCHP_RST_NONE;
		end
		samp_next = samp_reg;
		ch_next = ch_reg;
		cyc_next = cyc_reg;
		busy_next = busy_reg;
		conv_next = conv_reg;
		push_valid = 1'b0;
		push_word.channel = ch_reg;
		push_word.value = pick(samp_reg, ch_reg);
		if (cv_rise && !conv_reg) begin
			samp_next = analog_codes;
			busy_next = 1'b1;
			conv_next = 1'b1;
			ch_next = '0;
			cyc_next = '0;
		end else if (conv_reg) begin
			if (cyc_reg < 8'(ADCHP_CONV_CYC)) begin
				cyc_next = 8'(cyc_reg + 1'b1);
			end else begin
				push_valid = 1'b1;
				if (push_ready) begin
					cyc_next = '0;
					ch_next = ADCHP_CH_BITS'(ch_reg + 1'b1);
					if (ch_reg == ADCHP_CH_BITS'(ADCHP_CHANNELS - 1)) begin
						conv_next = 1'b0;
						busy_next = 1'b0;
					end
				end
			end
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			cv_sync_reg <= '0;
			cv_prev_reg <= 1'b0;
			samp_reg <= '0;
			ch_reg <= '0;
			cyc_reg <= '0;
			busy_reg <= 1'b0;
			conv_reg <= 1'b0;
		end else begin
			cv_sync_reg <= cv_sync_next;
			cv_prev_reg <= cv_prev_next;
			samp_reg <= samp_next;
			ch_reg <= ch_next;
			cyc_reg <= cyc_next;
			busy_reg <= busy_next;
			conv_reg <= conv_next;
		end
		// Reset length measurement runs through reset itself
		rst_prev_reg <= rst_prev_next;
		rst_cnt_reg <= rst_cnt_next;
		rst_kind_reg <= rst_kind_next;
	end
	assign busy = busy_reg;
	assign reset_kind = rst_kind_reg;
	adchp_fifo #(.WIDTH($bits(adchp_word_type)), .DEPTH(ADCHP_FIFO_DEPTH)) u_fifo (
		.clock(clock), .reset(reset),
		.in_data(push_word), .in_valid(push_valid), .in_ready(push_ready),
		.out_data(pop_word), .out_valid(pop_valid), .out_ready(pop_ready));
	// Handshake word transfer into the link domain
	logic lk_ack_reg, lk_ack_next;
	logic req_reg, req_next;
	logic [1:0] ack_sync_reg, ack_sync_next;
	adchp_word_type hold_reg, hold_next;
	always_comb begin
		ack_sync_next = {ack_sync_reg[0], lk_ack_reg};
		req_next = req_reg;
		hold_next = hold_reg;
		pop_ready = 1'b0;
		if (req_reg == ack_sync_reg[1] && pop_valid) begin
			pop_ready = 1'b1;
			hold_next = pop_word;
			req_next = !req_reg;
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			req_reg <= 1'b0;
			ack_sync_reg <= '0;
			hold_reg <= '0;
		end else begin
			req_reg <= req_next;
			ack_sync_reg <= ack_sync_next;
			hold_reg <= hold_next;
		end
	end
	// Link domain: read strobe falls start pulses, serial clock shifts
	logic [1:0] lk_req_sync_reg, lk_cs_sync_reg, lk_sel_sync_reg, lk_rst_sync_reg;
	logic lk_full_reg, lk_full_next;
	adchp_word_type lk_word_reg, lk_word_next;
	logic lk_half_reg, lk_half_next;
	logic [4:0] lk_bit_reg, lk_bit_next;
	adchp_pins_type lk_pins_reg, lk_pins_next;
	logic lk_first_reg, lk_first_next;
	logic [ADCHP_PINS-1:0] lk_cap_reg, lk_cap_next;
	logic lk_sel, lk_cs_n;
	always_comb begin
		lk_sel = lk_sel_sync_reg[1];
		lk_cs_n = lk_cs_sync_reg[1];
		lk_ack_next = lk_ack_reg;
		lk_full_next = lk_full_reg;
		lk_word_next = lk_word_reg;
		lk_half_next = lk_half_reg;
		lk_bit_next = lk_bit_reg;
		lk_first_next = lk_full_reg && lk_word_reg.channel == '0;
		lk_pins_next.out = '0;
		lk_pins_next.oe_n = '1;
		lk_cap_next = data_in;
		if (!lk_full_reg && lk_req_sync_reg[1] != lk_ack_reg) begin
			lk_word_next = hold_reg;
			lk_full_next = 1'b1;
			lk_ack_next = !lk_ack_reg;
			lk_half_next = 1'b0;
			lk_bit_next = 5'(ADCHP_RES_BITS - 1);
		end else if (!lk_cs_n && lk_full_reg) begin
			if (!lk_sel) begin
				lk_pins_next.oe_n = '0;
				lk_cap_next = lk_cap_reg;
				if (!lk_half_reg) begin
					lk_pins_next.out = lk_word_reg.value[ADCHP_TOP_BIT:ADCHP_LSB];
				end else begin
					lk_pins_next.out[ADCHP_TOP_BIT] = lk_word_reg.value[ADCHP_LSB];
				end
				lk_half_next = !lk_half_reg;
				lk_full_next = !lk_half_reg;
			end else begin
				// Serial lines on pins 5..10 in order E F G H A B; 2..4 idle
				lk_pins_next.oe_n[ADCHP_SER_LAST:ADCHP_SER_FIRST] = '0;
				lk_pins_next.out[ADCHP_SER_LAST - 1] = lk_word_reg.value[lk_bit_reg];
				lk_bit_next = 5'(lk_bit_reg - 1'b1);
				lk_full_next = lk_bit_reg != '0;
			end
		end
	end
	always_ff @(negedge link_clock) begin
		lk_req_sync_reg <= {lk_req_sync_reg[0], req_reg};
		lk_cs_sync_reg <= {lk_cs_sync_reg[0], chip_select_n};
		lk_sel_sync_reg <= {lk_sel_sync_reg[0], interface_select};
		lk_rst_sync_reg <= {lk_rst_sync_reg[0], reset};
		if (lk_rst_sync_reg[1]) begin
			lk_ack_reg <= 1'b0;
			lk_full_reg <= 1'b0;
			lk_word_reg <= '0;
			lk_half_reg <= 1'b0;
			lk_bit_reg <= '0;
			lk_pins_reg <= '{out: '0, oe_n: '1};
			lk_first_reg <= 1'b0;
			lk_cap_reg <= '0;
		end else begin
			lk_ack_reg <= lk_ack_next;
			lk_full_reg <= lk_full_next;
			lk_word_reg <= lk_word_next;
			lk_half_reg <= lk_half_next;
			lk_bit_reg <= lk_bit_next;
			lk_pins_reg <= lk_pins_next;
			lk_first_reg <= lk_first_next;
			lk_cap_reg <= lk_cap_next;
		end
	end
	assign data_out = lk_pins_reg.out;
	assign data_oe_n = lk_pins_reg.oe_n;
	assign first_channel_flag = lk_first_reg;
	assign host_bus_capture = lk_cap_reg;
	// Busy rises within three clocks of start edge and conversion spans all channels
	sequence s_start_seen;
		$rose(cv_sync_reg[1]) && !conv_reg;
	endsequence
	property p_busy_rise;
		@(posedge clock) disable iff (reset)
		s_start_seen |-> ##2 busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");
	property p_busy_hold;
		@(posedge clock) disable iff (reset)
		$fell(busy) |-> $past(ch_reg) == ADCHP_CH_BITS'(ADCHP_CHANNELS - 1);
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy fell early");
	property p_float;
		@(negedge link_clock) disable iff (lk_rst_sync_reg[1])
		!$past(lk_sel) && $past(lk_cs_n) |-> data_oe_n == '1;
	endproperty
	a_float: assert property (p_float) else $error("pins driven without select");
	property p_low_idle;
		@(negedge link_clock) disable iff (lk_rst_sync_reg[1])
		$past(lk_sel) |-> data_oe_n[ADCHP_LOW_LAST:ADCHP_LOW_FIRST] == '1;
	endproperty
	a_low_idle: assert property (p_low_idle) else $error("low pins driven in serial");

	// Reset clears busy
	property p_reset_idle;
		@(posedge clock)
		reset |=> !busy;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("busy high in reset");

	// Sampled codes hold through conversion
	property p_sample_hold;
		@(posedge clock) disable iff (reset)
		$past(conv_reg) && conv_reg |-> $stable(samp_reg);
	endproperty
	a_sample_hold: assert property (p_sample_hold) else $error("samples changed");

	// Second parallel pulse carries zeros below the top pin
	property p_second_zero;
		@(negedge link_clock) disable iff (lk_rst_sync_reg[1])
		$past(lk_half_reg) && !$past(lk_sel) && !data_oe_n[ADCHP_TOP_BIT]
			|-> data_out[ADCHP_TOP_BIT-1:ADCHP_LSB] == '0;
	endproperty
	a_second_zero: assert property (p_second_zero) else $error("second pulse not zero");

	// Serial lines are driven together
	property p_serial_lines;
		@(negedge link_clock) disable iff (lk_rst_sync_reg[1])
		!data_oe_n[ADCHP_SER_LAST-1] |-> data_oe_n[ADCHP_SER_LAST:ADCHP_SER_FIRST] == '0;
	endproperty
	a_serial_lines: assert property (p_serial_lines) else $error("serial lines split");

	// Busy span counter
	logic [9:0] busy_cnt_reg, busy_cnt_next;
	always_comb begin
		busy_cnt_next = '0;
		if (busy_reg) begin
			busy_cnt_next = (busy_cnt_reg == 10'h3FF) ? busy_cnt_reg : 10'(busy_cnt_reg + 1'b1);
		end
	end
	always_ff @(posedge clock) begin
		if (reset) begin
			busy_cnt_reg <= '0;
		end else begin
			busy_cnt_reg <= busy_cnt_next;
		end
	end
	property p_busy_span;
		@(posedge clock) disable iff (reset)
		$fell(busy) |-> busy_cnt_reg >= 10'(ADCHP_CHANNELS * ADCHP_CONV_CYC);
	endproperty
	a_busy_span: assert property (p_busy_span) else $error("busy too short");
endmodule : adchp_port

// ==== adchp_host_model.sv ====
// Host model: read strobe or serial clock, chip select, pin sampling
`timescale 1ns/1ps
module adchp_host_model
	import adchp_pkg::*;
(
	output logic link_clock,
	output logic chip_select_n,
	input wire logic [ADCHP_PINS-1:0] data_out,
	input wire logic [ADCHP_PINS-1:0] data_oe_n,
	input wire logic first_channel_flag
);
	initial begin
		link_clock = 1'b1;
		chip_select_n = 1'b1;
	end
	// Strobes with select high, for link side reset
	task automatic idle_pulses(input int n);
		repeat (n) begin
			#80 link_clock = 1'b0;
			#80 link_clock = 1'b1;
		end
	endtask : idle_pulses
	task automatic begin_frame(input logic cs_n);
		chip_select_n = cs_n;
		#40;
	endtask : begin_frame
	task automatic end_frame();
		#40 chip_select_n = 1'b1;
		#40;
	endtask : end_frame
	// One strobe low phase, pins read late in it
	task automatic pulse(output logic [ADCHP_PINS-1:0] p, output logic [ADCHP_PINS-1:0] o,
		output logic f);
		#20 link_clock = 1'b0;
		#70 p = data_out;
		o = data_oe_n;
		f = first_channel_flag;
		#10 link_clock = 1'b1;
		#60;
	endtask : pulse
	// Pulses until the given pin is driven, eight at most
	task automatic pulse_driven(input int pin, output logic [ADCHP_PINS-1:0] p,
		output logic [ADCHP_PINS-1:0] o, output logic f, output bit ok);
		ok = 1'b0;
		for (int i = 0; i < 8 && !ok; i++) begin
			pulse(p, o, f);
			ok = (o[pin] === 1'b0);
		end
	endtask : pulse_driven
endmodule : adchp_host_model

// ==== adchp_port_bench.sv ====
// Testbench for the converter host data port
`timescale 1ns/1ps
module adchp_port_bench;
	import adchp_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic conversion_start_strobe = 1'b0;
	logic interface_select = 1'b0;
	logic [ADCHP_CHANNELS*ADCHP_RES_BITS-1:0] analog_codes = '0;
	logic [ADCHP_PINS-1:0] host_pat = 17'h1F0F0;
	logic link_clock, chip_select_n, busy, first_channel_flag;
	logic [ADCHP_PINS-1:0] data_in, data_out, data_oe_n, host_bus_capture;
	logic [1:0] reset_kind;
	int err_total = 0;
	int comparisons = 0;
	always #50 clock = ~clock;
	assign data_in = (data_oe_n & host_pat) | (~data_oe_n & data_out);
	adchp_port dut(.clock(clock), .reset(reset), .link_clock(link_clock),
		.conversion_start_strobe(conversion_start_strobe), .interface_select(interface_select),
		.chip_select_n(chip_select_n), .analog_codes(analog_codes), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n), .busy(busy),
		.first_channel_flag(first_channel_flag), .reset_kind(reset_kind),
		.host_bus_capture(host_bus_capture));
	adchp_host_model host(.link_clock(link_clock), .chip_select_n(chip_select_n),
		.data_out(data_out), .data_oe_n(data_oe_n), .first_channel_flag(first_channel_flag));
	function automatic logic [ADCHP_RES_BITS-1:0] code(input int c, input int s);
		return ADCHP_RES_BITS'(c * 24'h0B3C5 + s * 24'h15A5B + 24'h20001);
	endfunction : code
	task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic do_reset(input int n, input adchp_rst_type kind);
		@(posedge clock) reset <= 1'b1;
		fork
			repeat (n) @(posedge clock);
			host.idle_pulses(3);
		join
		check("busy in reset", 18'h0, {17'h0, busy});
		check("oe_n in reset", 18'h1FFFF, {1'b0, data_oe_n});
		reset <= 1'b0;
		repeat (3) @(posedge clock);
		check("reset kind", {16'h0, kind}, {16'h0, reset_kind});
		$display("reset test done");
	endtask : do_reset
	task automatic convert(input int s);
		int n;
		@(posedge clock);
		for (int c = 0; c < ADCHP_CHANNELS; c++) analog_codes[c*18 +: 18] <= code(c, s);
		@(posedge clock) conversion_start_strobe <= 1'b1;
		repeat (6) @(posedge clock);
		check("busy after start", 18'h1, {17'h0, busy});
		for (int c = 0; c < ADCHP_CHANNELS; c++) analog_codes[c*18 +: 18] <= code(c, s + 9);
		conversion_start_strobe <= 1'b0;
		n = 0;
		while (busy === 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		check("busy length", 18'h1, 18'(n + 6 >= 3 + ADCHP_CHANNELS * (ADCHP_CONV_CYC + 1) && n < 200));
		repeat (20) @(posedge clock);
	endtask : convert
	task automatic test_parallel();
		logic [ADCHP_PINS-1:0] p, o;
		logic f;
		bit ok;
		logic [ADCHP_RES_BITS-1:0] w;
		@(posedge clock) interface_select <= 1'b0;
		convert(1);
		host.begin_frame(1'b1);
		repeat (4) host.pulse(p, o, f);
		host.end_frame();
		check("oe_n without select", 18'h1FFFF, {1'b0, o});
		host.begin_frame(1'b0);
		for (int c = 0; c < ADCHP_CHANNELS; c++) begin
			w = code(c, 1);
			host.pulse_driven(ADCHP_TOP_BIT, p, o, f, ok);
			check("drive seen", 18'h1, {17'h0, ok});
			check("first pulse", {1'b0, w[16:0]}, {1'b0, p});
			check("oe_n first", 18'h0, {1'b0, o});
			check("first flag", 18'(c == 0), {17'h0, f});
			host.pulse(p, o, f);
			check("second pulse", {1'b0, w[0], 16'h0}, {1'b0, p});
			check("oe_n second", 18'h0, {1'b0, o});
		end
		host.end_frame();
		@(posedge clock) host_pat <= 17'h0A5A5;
		host.idle_pulses(2);
		check("oe_n idle", 18'h1FFFF, {1'b0, data_oe_n});
		check("bus capture", 18'h0A5A5, {1'b0, host_bus_capture});
		$display("parallel read test done");
	endtask : test_parallel
	task automatic test_serial();
		logic [ADCHP_PINS-1:0] p, o;
		logic f;
		logic [ADCHP_RES_BITS-1:0] got;
		bit ok;
		@(posedge clock) interface_select <= 1'b1;
		convert(2);
		host.idle_pulses(3);
		host.begin_frame(1'b0);
		host.pulse_driven(ADCHP_SER_LAST - 1, p, o, f, ok);
		check("serial drive seen", 18'h1, {17'h0, ok});
		got[ADCHP_RES_BITS - 1] = p[ADCHP_SER_LAST - 1];
		check("serial flag", 18'h1, {17'h0, f});
		check("low pins oe_n", 18'h7, {15'h0, o[4:2]});
		for (int i = ADCHP_RES_BITS - 2; i >= 0; i--) begin
			host.pulse(p, o, f);
			got[i] = p[ADCHP_SER_LAST - 1];
			check("low pins oe_n", 18'h7, {15'h0, o[4:2]});
		end
		host.end_frame();
		check("serial word", code(0, 2), got);
		$display("serial read test done");
	endtask : test_serial
	initial begin
		do_reset(16, ADCHP_RST_PARTIAL);
		do_reset(ADCHP_FULL_CYC + 2, ADCHP_RST_FULL);
		test_parallel();
		test_serial();
		tally_and_finish();
	end
	initial begin
		#500000;
		err_total++;
		tally_and_finish();
	end
endmodule : adchp_port_bench
